// ### qdc_ctrl.sv
/*
 Quad DAC command and pin control: power-down modes, clear code,
 load override mask, load pin and clear pin. Assumes a 20 MHz clk,
 a free or gated link clock from the host, and that pins are async.
*/
// What this block does
// (RQ1) Execute command after full 32-bit frame
// (RQ2) Early sync rise discards the frame
// (RQ3) Code 0100 is power-down command
// (RQ4) Bits 9:8 pick the power mode
// (RQ5) Bits 3:0 select channels D to A
// (RQ6) Unselected channels keep power state
// (RQ7) Power-down keeps DAC register contents
// (RQ8) DAC register writable while powered down
// (RQ9) Wake-up takes about 4.5 us
// (RQ10) Clear pin acts on falling edge
// (RQ11) Clear loads all registers with clear code
// (RQ12) Code 0101 loads clear code setting
// (RQ13) Clear setting maps to 0000/8000/FFFF/none
// (RQ14) Clear setting resets to zero scale
// (RQ15) Next valid frame leaves cleared state
// (RQ16) Clear during frame aborts that write
// (RQ17) Outputs follow clear after 10.6 us
// (RQ18) Load low updates written channel
// (RQ19) Load pulse copies all input registers; masked channels are skipped
// (RQ20) Code 0010 writes then updates all
// (RQ21) Code 0110 loads override mask, reset 0
// (RQ22) Mask bit 1 acts as load low
`include "qdc_params.svh"
module qdc_ctrl (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clkEn,
    input wire logic linkClk,
    input wire logic syncN,
    input wire logic dataIn,
    input wire logic async_clear_n,
    input wire logic load_outputs_n,
    output qdc_pkg::qdc_chan_s chanOut [4],
    output logic clearActive,
    output qdc_pkg::qdc_mask_t maskOut
);
    import qdc_pkg::*;

    localparam int WakeCyc = `QDC_WAKE_CYC;
    localparam int ClearCyc = `QDC_CLEAR_CYC;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_CLRWAIT = 3'b010,
        ST_CLEARED = 3'b100
    } qdc_clr_e;

    qdc_frame_s rxFrame;
    logic rxToggle;
    logic [2:0] togSync_q;
    logic [1:0] clrSync_q;
    logic clrPrev_q;
    logic [1:0] ldSync_q;
    logic ldPrev_q;
    logic [1:0] syncSync_q;
    logic abort_q;
    logic [1:0] clearSel_q;
    qdc_mask_t mask_q;
    logic [15:0] inReg_q [4];
    logic [15:0] dacReg_q [4];
    qdc_pwr_e pwr_q [4];
    logic [7:0] wake_q [4];
    qdc_clr_e clrState_q;
    logic [8:0] clrCnt_q;
    logic [15:0] clearCode;
    logic frameEvt;
    logic clrFall;
    logic ldRise;
    logic frameValid;
    logic [3:0] addrHit;
    qdc_cmd_e cmd;

    // ------------------------------------------------------------------
    // Link side receiver
    // ------------------------------------------------------------------
    // Runs on the host's clock and is not held by clkEn; a frame that
    // ends while clkEn is low is taken once clkEn returns
    qdc_serial_rx rx (
        .linkClk(linkClk),
        .rst_b(rst_b),
        .syncN(syncN),
        .dataIn(dataIn),
        .frameOut(rxFrame),
        .frameToggle(rxToggle)
    );

    // ------------------------------------------------------------------
    // Crossings and pin edges
    // ------------------------------------------------------------------
    // Frame word is stable long before the toggle lands here
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            togSync_q <= 3'h0;
            clrSync_q <= 2'h3;
            clrPrev_q <= 1'b1;
            ldSync_q <= 2'h3;
            ldPrev_q <= 1'b1;
            syncSync_q <= 2'h3;
        end else if (clkEn) begin
            togSync_q <= {togSync_q[1:0], rxToggle};
            clrSync_q <= {clrSync_q[0], async_clear_n};
            clrPrev_q <= clrSync_q[1];
            ldSync_q <= {ldSync_q[0], load_outputs_n};
            ldPrev_q <= ldSync_q[1];
            syncSync_q <= {syncSync_q[0], syncN};
        end
    end

    assign frameEvt = togSync_q[2] ^ togSync_q[1];
    assign clrFall = clrPrev_q & ~clrSync_q[1]; // see (RQ10)
    // Low pulse ends on rise; level also covers the held-low case
    assign ldRise = ~ldPrev_q & ldSync_q[1];
    assign frameValid = frameEvt & ~abort_q & ~clrFall;
    assign cmd = qdc_cmd_e'(rxFrame.commandCode);

    // Clear seen inside a frame poisons that frame.
    // Set beats release when both come in one cycle.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            abort_q <= 1'b0;
        end else if (clkEn) begin
            if (clrFall && !syncSync_q[1]) begin
                abort_q <= 1'b1; // see (RQ16)
            end else if (frameEvt || syncSync_q[1]) begin
                abort_q <= 1'b0;
            end
        end
    end

    // Clear code lookup
    always_comb begin
        case (clearSel_q)
            2'h0: clearCode = `QDC_CODE_ZERO; // see (RQ13)
            2'h1: clearCode = `QDC_CODE_MID;
            2'h2: clearCode = `QDC_CODE_FULL;
            default: clearCode = `QDC_CODE_ZERO;
        endcase
    end

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            clearSel_q <= `QDC_CLRSEL_RST; // see (RQ14)
            mask_q <= `QDC_MASK_RST; // see (RQ21)
        end else if (clkEn && frameValid) begin
            if (cmd == QDC_CMD_CLRSEL) begin
                clearSel_q <= rxFrame.sel[1:0]; // see (RQ12)
            end
            if (cmd == QDC_CMD_MASK) begin
                mask_q <= rxFrame.sel; // see (RQ21)
            end
        end
    end

    // ------------------------------------------------------------------
    // Clear sequencer: wait with ready held low, then cleared state
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            clrState_q <= ST_IDLE;
            clrCnt_q <= 9'h000;
        end else if (clkEn) begin
            case (clrState_q)
                ST_IDLE: begin
                    if (clrFall && clearSel_q != 2'h3) begin
                        clrState_q <= ST_CLRWAIT;
                        clrCnt_q <= 9'(ClearCyc - 1); // see (RQ17)
                    end
                end
                ST_CLRWAIT: begin
                    // A valid frame ends clear mode even before the
                    // outputs have settled; ready follows at once
                    if (frameValid) begin
                        clrState_q <= ST_IDLE; // see (RQ15)
                    end else if (clrCnt_q == 9'h000) begin
                        clrState_q <= ST_CLEARED;
                    end else begin
                        clrCnt_q <= clrCnt_q - 9'h001;
                    end
                end
                ST_CLEARED: begin
                    if (frameValid) begin
                        clrState_q <= ST_IDLE; // see (RQ15)
                    end
                end
                default: clrState_q <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Per-channel registers, power state and output
    // ------------------------------------------------------------------
    genvar ch;
    generate
        for (ch = 0; ch < 4; ch++) begin : g_ch
            logic loadLow;
            logic hit;
            logic nextUpd;
            // Override bit makes this channel see load held low
            assign loadLow = mask_q[ch] | ~ldSync_q[1]; // see (RQ22)
            // Address F reaches every channel at once
            assign addrHit[ch] = rxFrame.channelAddress == 4'(ch) ||
                rxFrame.channelAddress == `QDC_ADDR_ALL;
            assign hit = addrHit[ch];

            // Register writes go on whatever the power mode
            always_ff @(posedge clk) begin
                if (!rst_b) begin
                    inReg_q[ch] <= `QDC_CODE_ZERO;
                    dacReg_q[ch] <= `QDC_CODE_ZERO;
                end else if (clkEn) begin
                    // Clear beats a frame ending in the same cycle
                    if (clrFall && clearSel_q != 2'h3) begin
                        inReg_q[ch] <= clearCode; // see (RQ11)
                        dacReg_q[ch] <= clearCode;
                    end else if (frameValid) begin
                        // see (RQ8)
                        case (cmd)
                            QDC_CMD_WR_IN: begin
                                if (hit) begin
                                    inReg_q[ch] <= rxFrame.data;
                                    if (loadLow) begin
                                        dacReg_q[ch] <= rxFrame.data;
                                    end // see (RQ18)
                                end
                            end
                            QDC_CMD_WR_ALL: begin
                                if (hit) begin
                                    inReg_q[ch] <= rxFrame.data;
                                    dacReg_q[ch] <= rxFrame.data;
                                end else begin
                                    dacReg_q[ch] <= inReg_q[ch];
                                end // see (RQ20)
                            end
                            QDC_CMD_WR_UPD: begin
                                if (hit) begin
                                    inReg_q[ch] <= rxFrame.data;
                                    dacReg_q[ch] <= rxFrame.data;
                                end
                            end
                            QDC_CMD_UPD_N: begin
                                if (hit) begin
                                    dacReg_q[ch] <= inReg_q[ch];
                                end
                            end
                            QDC_CMD_SWRST: begin
                                inReg_q[ch] <= `QDC_CODE_ZERO;
                                dacReg_q[ch] <= `QDC_CODE_ZERO;
                            end
                            default: begin
                            end
                        endcase
                    end else if (ldRise && !mask_q[ch]) begin
                        dacReg_q[ch] <= inReg_q[ch]; // see (RQ19)
                    end
                end
            end

            // Power mode; data registers untouched here
            always_ff @(posedge clk) begin
                if (!rst_b) begin
                    pwr_q[ch] <= QDC_PWR_NORMAL;
                end else if (clkEn && frameValid) begin
                    if (cmd == QDC_CMD_PWR && rxFrame.sel[ch]) begin
                        // see (RQ3) (RQ4) (RQ5) (RQ7)
                        pwr_q[ch] <= qdc_pwr_e'(rxFrame.pwrMode);
                    end else if (cmd == QDC_CMD_SWRST) begin
                        pwr_q[ch] <= QDC_PWR_NORMAL;
                    end // see (RQ6)
                end
            end

            // Wake delay counter after a power command returns to normal
            assign nextUpd = frameValid && cmd == QDC_CMD_PWR &&
                rxFrame.sel[ch] && rxFrame.pwrMode == 2'h0 &&
                pwr_q[ch] != QDC_PWR_NORMAL;
            always_ff @(posedge clk) begin
                if (!rst_b) begin
                    wake_q[ch] <= 8'h00;
                end else if (clkEn) begin
                    if (nextUpd) begin
                        wake_q[ch] <= 8'(WakeCyc); // see (RQ9)
                    end else if (wake_q[ch] != 8'h00) begin
                        wake_q[ch] <= wake_q[ch] - 8'h01;
                    end
                end
            end

            // Registered output view of the channel
            always_ff @(posedge clk) begin
                if (!rst_b) begin
                    chanOut[ch] <= '0;
                end else if (clkEn) begin
                    chanOut[ch].dacCode <= dacReg_q[ch];
                    chanOut[ch].pwrMode <= pwr_q[ch];
                    // Held off during clear delay and wake-up
                    chanOut[ch].ready <= pwr_q[ch] == QDC_PWR_NORMAL &&
                        wake_q[ch] == 8'h00 && clrState_q != ST_CLRWAIT;
                end
            end
        end
    endgenerate

    // Status outputs; clearActive spans the wait and the cleared state
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            clearActive <= 1'b0;
            maskOut <= `QDC_MASK_RST;
        end else if (clkEn) begin
            clearActive <= clrState_q != ST_IDLE;
            maskOut <= mask_q;
        end
    end
endmodule

// ### qdc_params.svh
/*
 Timing counts, field positions and reset values for the quad DAC
 control block. Assumes a 20 MHz system clock.
*/
`ifndef QDC_PARAMS_SVH
`define QDC_PARAMS_SVH
// ----------------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------------
`define QDC_FRAME_BITS 32
`define QDC_CMD_MSB 27
`define QDC_CMD_LSB 24
`define QDC_ADDR_MSB 23
`define QDC_ADDR_LSB 20
`define QDC_DATA_MSB 19
`define QDC_DATA_LSB 4
`define QDC_PWR_MSB 9
`define QDC_PWR_LSB 8
`define QDC_SEL_MSB 3
`define QDC_SEL_LSB 0
`define QDC_CLRSEL_MSB 1
`define QDC_CLRSEL_LSB 0
// ----------------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------------
`define QDC_CLRSEL_RST 2'h0
`define QDC_MASK_RST 4'h0
`define QDC_CODE_ZERO 16'h0000
`define QDC_CODE_MID 16'h8000
`define QDC_CODE_FULL 16'hFFFF
`define QDC_ADDR_ALL 4'hF
// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define QDC_CLK_HZ 20000000
`define QDC_WAKE_NS 4500
`define QDC_CLEAR_NS 10600
`define QDC_WAKE_CYC ((`QDC_WAKE_NS * (`QDC_CLK_HZ / 1000000)) / 1000)
`define QDC_CLEAR_CYC ((`QDC_CLEAR_NS * (`QDC_CLK_HZ / 1000000)) / 1000)
`endif

// ### qdc_pkg.sv
/*
 Types shared by the quad DAC control block.
 Assumes qdc_params.svh is on the include path.
*/
package qdc_pkg;
    // Command codes held in the four command bits
    typedef enum logic [3:0] {
        QDC_CMD_WR_IN = 4'h0,
        QDC_CMD_UPD_N = 4'h1,
        QDC_CMD_WR_ALL = 4'h2,
        QDC_CMD_WR_UPD = 4'h3,
        QDC_CMD_PWR = 4'h4,
        QDC_CMD_CLRSEL = 4'h5,
        QDC_CMD_MASK = 4'h6,
        QDC_CMD_SWRST = 4'h7
    } qdc_cmd_e;

    // Per-channel output power modes
    typedef enum logic [1:0] {
        QDC_PWR_NORMAL = 2'h0,
        QDC_PWR_1K = 2'h1,
        QDC_PWR_100K = 2'h2,
        QDC_PWR_TRI = 2'h3
    } qdc_pwr_e;

    // One decoded frame handed from link to system domain
    typedef struct packed {
        logic [3:0] commandCode;
        logic [3:0] channelAddress;
        logic [15:0] data;
        logic [1:0] pwrMode;
        logic [3:0] sel;
    } qdc_frame_s;

    // Shown state of one channel
    typedef struct packed {
        logic [15:0] dacCode;
        qdc_pwr_e pwrMode;
        logic ready;
    } qdc_chan_s;

    typedef logic [3:0] qdc_mask_t;
endpackage

// ### qdc_serial_rx.sv
/*
 Serial frame receiver on the link clock. Shifts 32 bits MSB first on
 falling link clock edges while frame sync is low, then toggles a flag
 holding the finished frame. Assumes the system side re-times the flag.
*/
`include "qdc_params.svh"
module qdc_serial_rx (
    input wire logic linkClk,
    input wire logic rst_b,
    input wire logic syncN,
    input wire logic dataIn,
    output qdc_pkg::qdc_frame_s frameOut,
    output logic frameToggle
);
    import qdc_pkg::*;

    logic [31:0] shift_q;
    logic [5:0] count_q;
    logic [5:0] count_d;
    logic [31:0] shift_d;

    // ------------------------------------------------------------------
    // Shift and count
    // ------------------------------------------------------------------
    assign shift_d = {shift_q[30:0], dataIn};
    assign count_d = count_q + 6'h01;

    // Sync high clears the count at once: an early rise drops the frame.
    // Reset clears it too, as the link clock is parked during reset.
    always_ff @(negedge linkClk or posedge syncN or negedge rst_b) begin
        if (syncN || !rst_b) begin
            count_q <= 6'h00; // see (RQ2)
        end else if (count_q != 6'h3F) begin
            shift_q <= shift_d; // see (RQ1)
            count_q <= (count_q == 6'h1F) ? 6'h3F : count_d;
        end
    end

    // Frame hand-over on the 32nd falling edge
    always_ff @(negedge linkClk or negedge rst_b) begin
        if (!rst_b) begin
            frameToggle <= 1'b0;
            frameOut <= '0;
        end else if (!syncN && count_q == 6'h1F) begin
            frameToggle <= ~frameToggle; // see (RQ1)
            frameOut.commandCode <= shift_d[`QDC_CMD_MSB:`QDC_CMD_LSB];
            frameOut.channelAddress <= shift_d[`QDC_ADDR_MSB:`QDC_ADDR_LSB];
            frameOut.data <= shift_d[`QDC_DATA_MSB:`QDC_DATA_LSB];
            frameOut.pwrMode <= shift_d[`QDC_PWR_MSB:`QDC_PWR_LSB];
            frameOut.sel <= shift_d[`QDC_SEL_MSB:`QDC_SEL_LSB];
        end
    end
endmodule

// ### qdc_ctrl_sva.sv
/*
 Port-level checker for qdc_ctrl: clear, power and mask timing.
 Assumes clkEn is held high and that it is bound to qdc_ctrl below.
*/
module qdc_ctrl_sva
    import qdc_pkg::*;
(
    input logic clk,
    input logic rst_b,
    input logic syncN,
    input logic async_clear_n,
    input logic load_outputs_n,
    input qdc_pkg::qdc_chan_s chanOut [4],
    input logic clearActive,
    input qdc_pkg::qdc_mask_t maskOut
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // ------------------------------------------------------------------
    // Helpers and assertions
    // ------------------------------------------------------------------
    logic sameCode;
    logic quiet;
    // All channels share one legal clear code
    assign sameCode = chanOut[0].dacCode == chanOut[1].dacCode
        && chanOut[1].dacCode == chanOut[2].dacCode
        && chanOut[2].dacCode == chanOut[3].dacCode
        && (chanOut[0].dacCode == 16'h0000
        || chanOut[0].dacCode == 16'h8000
        || chanOut[0].dacCode == 16'hFFFF);
    // No frame, clear or load activity at the pins
    assign quiet = syncN && async_clear_n && load_outputs_n;

    clear_code_a: assert property ($rose(clearActive) |=> sameCode)
        else $error("cleared channels differ");
    clear_cause_a: assert property (
        $rose(clearActive) |-> !$past(async_clear_n, 2))
        else $error("clear state without clear pin");
    clear_wait_a: assert property (
        $rose(clearActive) |=> !chanOut[0].ready [*8])
        else $error("outputs ready too soon after clear");
    clear_exit_a: assert property (
        syncN [*8] |=> !$fell(clearActive))
        else $error("clear state left without a frame");
    pwr_keep_a: assert property (
        $changed(chanOut[0].pwrMode) |-> $stable(chanOut[0].dacCode))
        else $error("power change altered code");
    wake_wait_a: assert property (
        chanOut[0].pwrMode == QDC_PWR_NORMAL
        && $past(chanOut[0].pwrMode) != QDC_PWR_NORMAL
        |=> !chanOut[0].ready [*8])
        else $error("wake-up delay too short");
    mask_quiet_a: assert property (syncN [*8] |=> $stable(maskOut))
        else $error("mask changed without a frame");
    pwr_quiet_a: assert property (
        syncN [*8] |=> $stable(chanOut[2].pwrMode))
        else $error("power mode changed without a frame");
    dac_hold_a: assert property (
        quiet [*8] |=> $stable(chanOut[3].dacCode))
        else $error("code changed without cause");

    // Main scenarios reached
    cover property ($rose(clearActive));
    cover property ($fell(clearActive));
    cover property ($changed(maskOut));
    cover property (chanOut[0].pwrMode == QDC_PWR_TRI);
endmodule

bind qdc_ctrl qdc_ctrl_sva qdc_ctrl_sva_i (.clk(clk), .rst_b(rst_b),
    .syncN(syncN), .async_clear_n(async_clear_n),
    .load_outputs_n(load_outputs_n), .chanOut(chanOut),
    .clearActive(clearActive), .maskOut(maskOut));

// ### qdc_host_model.sv
/*
 Host serial master model: link clock, frame sync and serial data.
 Assumes the bench calls send from one process at a time.
*/
module qdc_host_model (
    output logic linkClk,
    output logic syncN,
    output logic dataIn
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------------
    // Link driver
    // ------------------------------------------------------------------
    // Link clock parked high between frames, sync released
    initial begin
        linkClk = 1'b1;
        syncN = 1'b1;
        dataIn = 1'b0;
    end
    // Shift nBits MSB first; fewer than 32 is a commanded early stop
    task automatic send(input logic [31:0] frame, input int nBits);
        syncN = 1'b0;
        #62.5;
        for (int i = 31; i > 31 - nBits; i--) begin
            dataIn = frame[i];
            #62.5;
            linkClk = 1'b0;
            #62.5;
            linkClk = 1'b1;
        end
        #62.5;
        syncN = 1'b1;
        // Released data shows no stale level
        dataIn = ~dataIn;
    endtask
endmodule

// ### tb_qdc_ctrl.sv
/*
 Self-checking bench for qdc_ctrl driven by the host serial model.
 Assumes the package is compiled first; clkEn is held high.
*/
module tb_qdc_ctrl
    import qdc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------------
    // Environment
    // ------------------------------------------------------------------
    logic clk = 1'b0;
    logic rst_b = 1'b1;
    logic async_clear_n = 1'b1;
    logic load_outputs_n = 1'b0;
    logic linkClk, syncN, dataIn, clearActive;
    qdc_chan_s chanOut [4];
    qdc_mask_t maskOut;
    int errorCnt = 0;
    int comparisons = 0;

    // 20 MHz system clock
    always #25 clk = ~clk;

    qdc_host_model qdc_host_model_i (.linkClk(linkClk), .syncN(syncN),
        .dataIn(dataIn));
    qdc_ctrl qdc_ctrl_i (.clk(clk), .rst_b(rst_b), .clkEn(1'b1),
        .linkClk(linkClk), .syncN(syncN), .dataIn(dataIn),
        .async_clear_n(async_clear_n), .load_outputs_n(load_outputs_n),
        .chanOut(chanOut), .clearActive(clearActive), .maskOut(maskOut));

    // Frame layout: command, address, then 20 body bits
    function automatic logic [31:0] mk(logic [3:0] cmd, logic [3:0] ad,
        logic [19:0] body);
        return {4'h0, cmd, ad, body};
    endfunction
    task automatic chkCode(string nm, logic [15:0] exp, logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            errorCnt++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic chkField(string nm, logic [3:0] exp, logic [3:0] got);
        comparisons++;
        if (got !== exp) begin
            errorCnt++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Inputs move 2 ns after the rising edge
    task automatic tick(int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    // Settle time covers the 4-5 clk answer latency
    task automatic frame(logic [31:0] f);
        qdc_host_model_i.send(f, 32);
        tick(8);
    endtask
    task automatic pulseClear;
        tick(1);
        async_clear_n = 1'b0;
        tick(10);
        async_clear_n = 1'b1;
        tick(4);
    endtask
    task automatic results;
        $display("comparisons %0d mismatches %0d", comparisons, errorCnt);
        if (errorCnt == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic testReset;
        chkField("mask", 4'h0, maskOut);
        frame(mk(QDC_CMD_WR_IN, 4'hF, {16'h1234, 4'h0}));
        chkCode("dacLoadLow", 16'h1234, chanOut[3].dacCode);
        pulseClear;
        chkCode("clrDefault", 16'h0000, chanOut[2].dacCode);
        $display("test reset done");
    endtask
    task automatic testPower;
        for (logic [2:0] m = 1; m < 4; m++) begin
            frame(mk(QDC_CMD_PWR, 4'h7, {10'h0, m[1:0], 4'h0, 4'h5}));
            chkField("pwrSel", {2'h0, m[1:0]}, {2'h0, chanOut[2].pwrMode});
            chkField("pwrKeep", 4'h0, {2'h0, chanOut[1].pwrMode});
        end
        frame(mk(QDC_CMD_WR_IN, 4'h0, {16'hABCD, 4'h0}));
        chkCode("dacInPd", 16'hABCD, chanOut[0].dacCode);
        chkField("pwrTri", 4'h3, {2'h0, chanOut[0].pwrMode});
        frame(mk(QDC_CMD_PWR, 4'h0, {10'h0, 2'h0, 4'h0, 4'hF}));
        chkField("wakeBusy", 4'h0, {3'h0, chanOut[0].ready});
        tick(100);
        chkField("wakeDone", 4'h1, {3'h0, chanOut[0].ready});
        chkCode("dacKept", 16'hABCD, chanOut[0].dacCode);
        $display("test power done");
    endtask
    task automatic testLoad;
        load_outputs_n = 1'b1;
        tick(4);
        frame(mk(QDC_CMD_WR_IN, 4'h1, {16'hA5A5, 4'h0}));
        frame(mk(QDC_CMD_WR_IN, 4'h3, {16'h7777, 4'h0}));
        chkCode("ldHold", 16'h0000, chanOut[1].dacCode);
        load_outputs_n = 1'b0;
        tick(4);
        load_outputs_n = 1'b1;
        tick(8);
        chkCode("ldPulse", 16'hA5A5, chanOut[1].dacCode);
        frame(mk(QDC_CMD_WR_IN, 4'h3, {16'h6666, 4'h0}));
        frame(mk(QDC_CMD_WR_ALL, 4'h2, {16'h5A5A, 4'h0}));
        chkCode("swUpdOwn", 16'h5A5A, chanOut[2].dacCode);
        chkCode("swUpdAll", 16'h6666, chanOut[3].dacCode);
        $display("test load done");
    endtask
    task automatic testMask;
        frame(mk(QDC_CMD_MASK, 4'h0, 20'h00008));
        chkField("maskSet", 4'h8, maskOut);
        frame(mk(QDC_CMD_WR_IN, 4'hF, {16'h3C3C, 4'h0}));
        chkCode("maskOn", 16'h3C3C, chanOut[3].dacCode);
        chkCode("maskOff", 16'hABCD, chanOut[0].dacCode);
        frame(mk(QDC_CMD_WR_UPD, 4'h1, {16'h1111, 4'h0}));
        chkCode("wrUpd", 16'h1111, chanOut[1].dacCode);
        frame(mk(QDC_CMD_UPD_N, 4'h0, 20'h00000));
        chkCode("updOne", 16'h3C3C, chanOut[0].dacCode);
        $display("test mask done");
    endtask
    task automatic testClear;
        logic [15:0] codes [3] = '{16'h0000, 16'h8000, 16'hFFFF};
        for (int s = 0; s < 3; s++) begin
            frame(mk(QDC_CMD_CLRSEL, 4'h0, {18'h0, 2'(s)}));
            pulseClear;
            chkCode("clrCode", codes[s], chanOut[1].dacCode);
            chkField("clrOn", 4'h1, {3'h0, clearActive});
        end
        frame(mk(QDC_CMD_CLRSEL, 4'h0, 20'h00003));
        chkField("clrExit", 4'h0, {3'h0, clearActive});
        pulseClear;
        chkField("clrNoop", 4'h0, {3'h0, clearActive});
        chkCode("clrNoopCode", 16'hFFFF, chanOut[0].dacCode);
        $display("test clear done");
    endtask
    task automatic testAbort;
        frame(mk(QDC_CMD_CLRSEL, 4'h0, 20'h00000));
        qdc_host_model_i.send(mk(QDC_CMD_MASK, 4'h0, 20'h0000F), 31);
        tick(8);
        chkField("earlySync", 4'h8, maskOut);
        fork
            qdc_host_model_i.send(mk(QDC_CMD_MASK, 4'h0, 20'h0000F), 32);
            begin
                tick(20);
                async_clear_n = 1'b0;
            end
        join
        tick(8);
        async_clear_n = 1'b1;
        tick(8);
        chkField("clrAbort", 4'h8, maskOut);
        frame(mk(QDC_CMD_MASK, 4'h0, 20'h00006));
        chkField("afterAbort", 4'h6, maskOut);
        chkField("abortExit", 4'h0, {3'h0, clearActive});
        $display("test abort done");
    endtask

    // Main sequence: reset for 3 clocks, then each scenario
    initial begin
        // A real falling edge, so the link-side flops see reset too
        #1;
        rst_b = 1'b0;
        repeat (3) @(posedge clk);
        #2;
        rst_b = 1'b1;
        tick(2);
        testReset;
        testPower;
        testLoad;
        testMask;
        testClear;
        testAbort;
        results;
    end
    // About 22 frames of about 4.1 us plus waits; 2 ms leaves a wide margin
    initial begin
        #2_000_000;
        errorCnt++;
        results;
    end
endmodule
